// ---- common/qdac_pkg.sv ----
// What this block does
// R1 - One 16-bit word: address, control, 12-bit code
// R2 - Four independent 12-bit channels, address selects
// R3 - Frame sync falling edge starts a frame
// R4 - Traffic ignored while chip select high
// R5 - Load strobe high blocks all output updates
// R6 - Output latches load only while strobe low
// R7 - Power-down pin low powers down everything
// R8 - Speed bit picks 3 us or 9 us settling
// R9 - Sleep bit powers down the addressed channel
// R10 - MSB first, one bit per clock falling edge
// R11 - Sixteen bits or early sync rise commits word
// R12 - Bits 15:14 address, 13 sleep, 12 fast, 11:0 code
// R13 - Reset clears codes and control bits
// R14 - Address 0..3 selects channels A..D
// R15 - Select-aborted partial frame changes nothing
`default_nettype none
package qdac_pkg;

  // Serial word layout
  localparam int WORD_BITS    = 16;
  localparam int CODE_BITS    = 12;
  localparam int NUM_CHAN     = 4;
  localparam int CNT_BITS     = 5;
  localparam int ADDR_HI      = 15;
  localparam int ADDR_LO      = 14;
  localparam int SLEEP_POS    = 13;
  localparam int FAST_POS     = 12;
  localparam logic [CNT_BITS-1:0] FULL_CNT = 5'h10;
  localparam logic [CNT_BITS-1:0] LAST_CNT = 5'h0f;

  // Settling times and system clock
  localparam int CLK_PERIOD_NS  = 20;
  localparam int FAST_SETTLE_NS = 3000;
  localparam int SLOW_SETTLE_NS = 9000;
  localparam int SETTLE_BITS    = 10;
  localparam logic [SETTLE_BITS-1:0] FAST_CYC = SETTLE_BITS'(
    (FAST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [SETTLE_BITS-1:0] SLOW_CYC = SETTLE_BITS'(
    (SLOW_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WORDS  = 8'h08;
  localparam logic [7:0] REG_CHAN0  = 8'h10;
  localparam logic [7:0] REG_CHAN3  = 8'h1c;

  // Control register fields and reset value
  localparam int CTRL_SOFT_PD   = 0;
  localparam int CTRL_SOFT_HOLD = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One channel's settings
  typedef struct packed {
    logic                 sleep_bit;
    logic                 fast_settle_bit;
    logic [CODE_BITS-1:0] code;
  } qdac_chan_t;

  // Status captured by the link receiver
  typedef struct packed {
    logic [WORD_BITS-1:0] word;
    logic [CNT_BITS-1:0]  len;
    logic                 word_tgl;
    logic                 frame_tgl;
    logic                 abort;
  } qdac_link_t;

endpackage
`default_nettype wire

// ---- hw/qdac_link_rx.sv ----
`default_nettype none
// Serial receiver running on the falling edge of the serial clock
module qdac_link_rx
  import qdac_pkg::*;
(
  input  wire logic sclk,
  input  wire logic link_rst_n,
  input  wire logic frame_sync,
  input  wire logic sel_n,
  input  wire logic ser_data,
  output qdac_link_t link
);

  logic [CNT_BITS-1:0]  cnt_q;    // Bits taken in this frame
  logic [WORD_BITS-1:0] shift_q;  // Shift register
  logic [CNT_BITS-1:0]  len_q;    // Length of last frame
  logic                 wtgl_q;   // Toggles per full word
  logic                 ftgl_q;   // Toggles per frame start
  logic                 abort_q;  // Frame dropped by select
  logic                 take;     // Bit accepted this edge

  // Bits are taken only in a frame, with select low, up to sixteen
  assign take = !frame_sync && !sel_n && (cnt_q != FULL_CNT); // R4

  // Sync high clears the count, so its fall starts a new frame
  always_ff @(negedge sclk or negedge link_rst_n or posedge frame_sync) begin
    if (!link_rst_n) begin
      cnt_q <= '0;
    end else if (frame_sync) begin
      cnt_q <= '0; // R3
    end else if (take) begin
      cnt_q <= cnt_q + CNT_BITS'(1);
    end
  end

  // Shift MSB first and keep length and event toggles
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_q <= '0;
      len_q   <= '0;
      wtgl_q  <= 1'b0;
      ftgl_q  <= 1'b0;
      abort_q <= 1'b0;
    end else if (take) begin
      shift_q <= {shift_q[WORD_BITS-2:0], ser_data}; // R10
      len_q   <= cnt_q + CNT_BITS'(1);
      if (cnt_q == '0) begin
        ftgl_q  <= ~ftgl_q;
        abort_q <= 1'b0;
      end
      // Sixteenth bit closes the word unless the frame was dropped
      if (cnt_q == LAST_CNT && !abort_q) begin
        wtgl_q <= ~wtgl_q; // R1 R11
      end
    end else if (sel_n && !frame_sync && cnt_q != '0 && cnt_q != FULL_CNT)
    begin
      abort_q <= 1'b1; // R15
    end
  end

  // Everything stays static between frames for the other domain
  assign link = '{word: shift_q, len: len_q, word_tgl: wtgl_q,
                  frame_tgl: ftgl_q, abort: abort_q};

endmodule
`default_nettype wire

// ---- hw/qdac_top.sv ----
`default_nettype none
// Quad converter control: serial link, latches, AXI4-Lite registers
module qdac_top
  import qdac_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                sclk,
  input  wire logic                frame_sync,
  input  wire logic                sel_n,
  input  wire logic                ser_data,
  input  wire logic                load_strobe_n,
  input  wire logic                hw_powerdown_n,
  output qdac_chan_t [NUM_CHAN-1:0] chan_out,
  output logic [NUM_CHAN-1:0]      chan_on,
  output logic [NUM_CHAN-1:0]      chan_settling
);

  // Address decode shared by read and write paths
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_WORDS)
           || (a >= REG_CHAN0 && a <= REG_CHAN3 && a[1:0] == 2'h0);
  endfunction

  // Settling count chosen by the speed bit
  function automatic logic [SETTLE_BITS-1:0] settle_len(input logic fast);
    settle_len = fast ? FAST_CYC : SLOW_CYC; // R8
  endfunction

  qdac_link_t                   link;        // Link-domain status
  logic                         link_rst_q;  // Reset toward link domain
  logic [6:0]                   sy1_q;       // First sync stage
  logic [6:0]                   sy2_q;       // Second sync stage
  logic                         fs_s, sel_s, ld_s, pd_s;
  logic                         wt_s, ft_s, ab_s;
  logic                         fs_d1_q;     // Sync history for edges
  logic                         wt_seen_q;   // Last word toggle used
  logic                         ft_seen_q;   // Last frame handled
  logic                         fs_rise;     // Frame sync rose
  logic                         full_cmt;    // Full word arrived
  logic                         part_cmt;    // Early-ended word
  logic                         commit;      // Word goes to input latch
  logic [WORD_BITS-1:0]         cw;          // Word being committed
  qdac_chan_t [NUM_CHAN-1:0]    in_q;        // Input latches
  logic [NUM_CHAN-1:0]          pend_q;      // Input newer than output
  qdac_chan_t [NUM_CHAN-1:0]    out_q;       // Output latches
  logic [SETTLE_BITS-1:0]       settle_q [NUM_CHAN];
  logic [NUM_CHAN-1:0]          on_q;        // Channel powered
  logic [1:0]                   ctrl_q;      // Software control bits
  logic [15:0]                  words_q;     // Committed word count
  logic                         upd_block;   // Output update held
  logic                         pd_all;      // Global power-down

  // Idle pin levels, so no false sync edge follows reset
  localparam logic [6:0] SYNC_IDLE = 7'h68;

  qdac_link_rx u_rx (
    .sclk       (sclk),
    .link_rst_n (link_rst_q),
    .frame_sync (frame_sync),
    .sel_n      (sel_n),
    .ser_data   (ser_data),
    .link       (link)
  );

  // Link reset follows the system reset from a flop
  always_ff @(posedge aclk) begin
    link_rst_q <= aresetn;
  end

  // Two-stage synchronisers for pins and link-domain levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_q <= SYNC_IDLE;
      sy2_q <= SYNC_IDLE;
    end else begin
      sy1_q <= {frame_sync, sel_n, load_strobe_n, hw_powerdown_n,
                link.word_tgl, link.frame_tgl, link.abort};
      sy2_q <= sy1_q;
    end
  end
  assign {fs_s, sel_s, ld_s, pd_s, wt_s, ft_s, ab_s} = sy2_q;

  // Edge history and event bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fs_d1_q   <= 1'b1;
      wt_seen_q <= wt_s;
      ft_seen_q <= ft_s;
    end else begin
      fs_d1_q <= fs_s;
      if (full_cmt) begin
        wt_seen_q <= wt_s;
        ft_seen_q <= ft_s;
      end else if (fs_rise) begin
        ft_seen_q <= ft_s;
      end
    end
  end

  assign fs_rise  = fs_s && !fs_d1_q;
  assign full_cmt = (wt_s != wt_seen_q); // R11
  // Early sync rise moves a partial word unless select dropped it
  assign part_cmt = fs_rise && !full_cmt && (ft_s != ft_seen_q)
                 && !ab_s && !sel_s && link.len != '0
                 && link.len != FULL_CNT; // R11 R15
  assign commit   = full_cmt || part_cmt;
  assign cw       = link.word;

  // Input latches take the addressed channel's fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_q <= '0; // R13
    end else if (commit) begin
      in_q[cw[ADDR_HI:ADDR_LO]] <= '{sleep_bit: cw[SLEEP_POS],
        fast_settle_bit: cw[FAST_POS],
        code: cw[CODE_BITS-1:0]}; // R2 R12 R14
    end
  end

  assign upd_block = ld_s || ctrl_q[CTRL_SOFT_HOLD];

  // Pending flags: a new word wins over the transfer clearing it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (commit && cw[ADDR_HI:ADDR_LO] == 2'(i)) begin
          pend_q[i] <= 1'b1;
        end else if (!upd_block) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // Output latches copy pending inputs together when strobe is low and soft hold is clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= '0; // R13
    end else if (!upd_block) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (pend_q[i]) begin
          out_q[i] <= in_q[i]; // R5 R6
        end
      end
    end
  end

  // Settling timers restart on each output update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        settle_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (!upd_block && pend_q[i]) begin
          settle_q[i] <= settle_len(in_q[i].fast_settle_bit); // R8
        end else if (settle_q[i] != '0) begin
          settle_q[i] <= settle_q[i] - SETTLE_BITS'(1);
        end
      end
    end
  end

  assign pd_all = !pd_s || ctrl_q[CTRL_SOFT_PD];

  // Power state: pin or soft power-down overrides, else each channel's sleep bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        on_q[i] <= !pd_all && !out_q[i].sleep_bit; // R7 R9
      end
    end
  end

  // Count of words committed, for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      words_q <= '0;
    end else if (commit) begin
      words_q <= words_q + 16'h0001;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_out      <= '0;
      chan_on       <= '0;
      chan_settling <= '0;
    end else begin
      chan_out <= out_q;
      chan_on  <= on_q;
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_settling[i] <= (settle_q[i] != '0);
      end
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  logic        aw_have_q, w_have_q;  // Address / data held
  logic [7:0]  aw_addr_q;            // Held write address
  logic [31:0] w_data_q;             // Held write data
  logic [3:0]  w_strb_q;             // Held byte strobes
  logic        do_wr;                // Perform write now
  logic [31:0] rd_d;                 // Read data mux

  assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_have_q     <= 1'b0;
      aw_addr_q     <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_have_q     <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_have_q     <= 1'b0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_have_q     <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
    end else if (do_wr) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response and control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      ctrl_q       <= CTRL_RESET;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      if (aw_addr_q == REG_CTRL && w_strb_q[0]) begin
        ctrl_q <= w_data_q[1:0];
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data selection
  always_comb begin
    rd_d = '0;
    if (s_axi_araddr == REG_CTRL) begin
      rd_d[1:0] = ctrl_q;
    end else if (s_axi_araddr == REG_STATUS) begin
      rd_d[15:0] = {chan_settling, on_q, pend_q,
                    1'b0, sel_s, ld_s, pd_s};
    end else if (s_axi_araddr == REG_WORDS) begin
      rd_d[15:0] = words_q;
    end else if (addr_ok(s_axi_araddr)) begin
      rd_d[13:0] = out_q[s_axi_araddr[3:2]];
    end
  end

  // Read channel: data one edge after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_d;
      s_axi_rresp   <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  strobe_hold_a: assert property (upd_block |=> $stable(out_q)) // R5
    else $error("output latch changed while updates held");
  load_pass_a: assert property (!upd_block && pend_q[0] |=> // R6
    out_q[0] == $past(in_q[0]))
    else $error("channel 0 missed its update");
  pd_override_a: assert property (!pd_s |=> on_q == '0) // R7
    else $error("channel powered during hardware power-down");
  sleep_off_a: assert property (out_q[1].sleep_bit |=> !on_q[1]) // R9
    else $error("sleeping channel left powered");
  settle_len_a: assert property ( // R8
    !upd_block && pend_q[2] && in_q[2].fast_settle_bit
    |=> settle_q[2] == FAST_CYC ##1 settle_q[2] == FAST_CYC - 10'h001)
    else $error("fast settling count wrong");
  route_word_a: assert property (commit |=> // R2 R12 R14
    in_q[$past(cw[ADDR_HI:ADDR_LO])].code == $past(cw[CODE_BITS-1:0]))
    else $error("word landed in wrong channel");
  abort_keep_a: assert property ( // R15
    fs_rise && !full_cmt && (ab_s || sel_s) |=> $stable(in_q))
    else $error("aborted frame changed a latch");
  word_take_a: assert property ($changed(wt_s) |-> commit) // R11
    else $error("full word not committed");
  reset_clear_a: assert property (@(posedge aclk) disable iff (1'b0) // R13
    !aresetn |=> out_q == '0 && in_q == '0 && pend_q == '0)
    else $error("reset left latches set");

  full_word_c: cover property (full_cmt);
  part_word_c: cover property (part_cmt);
  multi_upd_c: cover property (!upd_block && pend_q[0] && pend_q[1]);
  hw_pd_c:     cover property (!pd_s && out_q[0].sleep_bit == 1'b0);

endmodule
`default_nettype wire

// ---- bench/qdac_host_model.sv ----
`default_nettype none
// Host serial port: frames words onto the link, clock idles high
module qdac_host_model (
  output logic sclk,
  output logic frame_sync,
  output logic sel_n,
  output logic ser_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels; the link clock stands still between frames
  initial begin
    sclk = 1'h1;
    frame_sync = 1'h1;
    sel_n = 1'h1;
    ser_data = 1'h0;
  end

  // Shift n bits MSB first; drop_at below n raises select mid-frame
  task automatic send(input logic [15:0] w, input int n, input int drop_at);
    // Odd offset keeps the link phase unrelated to the system clock
    #17;
    sel_n = 1'h0;
    #15;
    frame_sync = 1'h0;
    for (int i = 0; i < n; i++) begin
      // Deliberate abort of the frame
      if (i == drop_at) sel_n = 1'h1;
      ser_data = w[15-i];
      #40;
      sclk = 1'h0;
      #40;
      sclk = 1'h1;
    end
    #20;
    frame_sync = 1'h1;
    #20;
    sel_n = 1'h1;
    // Released data line shows the inverse of the last bit
    ser_data = ~ser_data;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_quad_dac_serial_control.sv ----
`default_nettype none
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("mismatch at %0t got %h exp %h", $time, got, exp); \
  end \
end
// Self-checking bench: serial host model, AXI master, reference model
module tb_quad_dac_serial_control
  import qdac_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        load_strobe_n = 1'h0, hw_powerdown_n = 1'h1;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic   s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic   sclk, frame_sync, sel_n, ser_data;
  wire qdac_chan_t [NUM_CHAN-1:0] chan_out;
  wire logic [NUM_CHAN-1:0]       chan_on, chan_settling;
  // Reference model state
  logic [13:0] in_lat [4];
  logic [13:0] out_lat [4];
  logic [3:0]  pend;
  logic [15:0] sh_m;
  logic        held;
  logic [1:0]  ctrl_m;
  int          words_m, err_total, check_count;
  logic [31:0] rnd = 32'h1f;

  qdac_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclk, .frame_sync,
    .sel_n, .ser_data, .load_strobe_n, .hw_powerdown_n, .chan_out,
    .chan_on, .chan_settling);

  qdac_host_model host (.sclk, .frame_sync, .sel_n, .ser_data);

  // System clock, 20 ns
  always #10 aclk = ~aclk;

  // Pseudo-random codes
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Pending codes move to the outputs once the hold is gone
  task automatic release_m();
    for (int i = 0; i < 4; i++) begin
      if (!held && pend[i]) begin
        out_lat[i] = in_lat[i];
        pend[i] = 1'h0;
      end
    end
  endtask

  // Model a commit of the shift register as it stands
  task automatic commit(input logic [15:0] v);
    in_lat[v[15:14]] = v[13:0];
    pend[v[15:14]] = 1'h1;
    words_m++;
    release_m();
  endtask

  // Outputs and power state against the model
  task automatic check_outs();
    for (int i = 0; i < NUM_CHAN; i++) begin
      `CHK(chan_out[i], out_lat[i])
      `CHK(chan_on[i], hw_powerdown_n && !ctrl_m[0] && !out_lat[i][13])
    end
  endtask

  // One serial frame, model update, then compare
  task automatic frame(input logic [15:0] w, input int n, input int drop);
    host.send(w, n, drop);
    // Taken bits enter the model's shift register, older bits stay
    for (int i = 0; i < n && i < drop && i < 16; i++) begin
      sh_m = {sh_m[14:0], w[15-i]};
    end
    if (drop >= n) commit(sh_m);
    repeat (12) @(posedge aclk);
    check_outs();
  endtask

  // AXI4-Lite write; address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'h1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_done && s_axi_wready === 1'h1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  // AXI4-Lite read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Counts and verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #1000000;
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [15:0] w;
    logic [31:0] rd;
    logic [1:0]  rs;
    err_total = 0;
    check_count = 0;
    pend = 4'h0;
    sh_m = 16'h0;
    held = 1'h0;
    ctrl_m = 2'h0;
    words_m = 0;
    for (int i = 0; i < 4; i++) begin
      in_lat[i] = 14'h0;
      out_lat[i] = 14'h0;
    end
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (8) @(posedge aclk);
    check_outs();
    axi_rd(REG_CTRL, rd, rs);
    `CHK(rd, 32'h0)
    // Every address and every sleep/speed combination
    for (int i = 0; i < 8; i++) begin
      rnd = xorshift(rnd);
      w = {i[1:0], i[2:1], rnd[11:0]};
      frame(w, 16, 99);
      `CHK(chan_settling[i%4], 1'h1)
      repeat (200) @(posedge aclk);
      `CHK(chan_settling[i%4], ~w[12])
    end
    axi_rd(REG_CHAN3, rd, rs);
    `CHK(rd, {18'h0, out_lat[3]})
    `CHK(rs, RESP_OKAY)
    // Strobe high: two channels wait, then update together
    @(posedge aclk);
    load_strobe_n <= 1'h1;
    held = 1'h1;
    repeat (4) @(posedge aclk);
    frame(16'h5a5a, 16, 99);
    frame(16'h8c3c, 16, 99);
    @(posedge aclk);
    load_strobe_n <= 1'h0;
    held = 1'h0;
    release_m();
    repeat (8) @(posedge aclk);
    check_outs();
    // Select dropped mid-frame, then a frame ended early
    frame(16'hffff, 16, 7);
    frame(16'hc3a5, 10, 99);
    axi_rd(REG_WORDS, rd, rs);
    `CHK(rd, 32'(words_m))
    // Power-down pin, then soft power-down, then an unmapped write
    @(posedge aclk);
    hw_powerdown_n <= 1'h0;
    repeat (6) @(posedge aclk);
    check_outs();
    @(posedge aclk);
    hw_powerdown_n <= 1'h1;
    axi_wr(REG_CTRL, 32'h1, rs);
    ctrl_m = 2'h1;
    `CHK(rs, RESP_OKAY)
    repeat (6) @(posedge aclk);
    check_outs();
    axi_wr(REG_CTRL, 32'h0, rs);
    ctrl_m = 2'h0;
    axi_wr(8'h40, 32'h1, rs);
    `CHK(rs, RESP_SLVERR)
    repeat (6) @(posedge aclk);
    check_outs();
    // Soft hold acts like the strobe; status shows the waiting channel
    axi_wr(REG_CTRL, 32'h2, rs);
    ctrl_m = 2'h2;
    held = 1'h1;
    frame(16'h1abc, 16, 99);
    axi_rd(REG_STATUS, rd, rs);
    `CHK(rd[7:0], 8'h15)
    `CHK(rs, RESP_OKAY)
    axi_wr(REG_CTRL, 32'h0, rs);
    ctrl_m = 2'h0;
    held = 1'h0;
    release_m();
    repeat (6) @(posedge aclk);
    check_outs();
    close_out();
  end
endmodule
`default_nettype wire
